// ===== design/usr_pkg.sv
// Shared constants, field layouts and types of the serial port control block
package usr_pkg;
	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] USR_IDX_RCV = 8'h13;
	localparam logic [7:0] USR_IDX_XMT = 8'h15;
	localparam logic [7:0] USR_IDX_DIV = 8'h17;

	// ==========================================================
	// Receive status/control field positions
	localparam int USR_RC_PEN  = 7;
	localparam int USR_RC_RX9  = 6;
	localparam int USR_RC_SRE  = 5;
	localparam int USR_RC_CRE  = 4;
	localparam int USR_RC_FER  = 2;
	localparam int USR_RC_OVR  = 1;
	localparam int USR_RC_R9D  = 0;
	// Transmit status/control field positions
	localparam int USR_TC_CSS  = 7;
	localparam int USR_TC_TX9  = 6;
	localparam int USR_TC_TEN  = 5;
	localparam int USR_TC_SYN  = 4;
	localparam int USR_TC_EMP  = 1;
	localparam int USR_TC_T9D  = 0;

	// ==========================================================
	// Values after reset
	localparam logic [7:0] USR_RCV_RST = 8'h00;
	localparam logic [7:0] USR_XMT_RST = 8'h02;
	localparam logic [7:0] USR_DIV_RST = 8'h00;

	// ==========================================================
	// Base clock prescale counts per mode
	localparam logic [5:0] USR_PRE_ASYNC = 6'h3f;
	localparam logic [5:0] USR_PRE_SYNC  = 6'h03;

	// ==========================================================
	// Types
	typedef struct packed {
		logic       en;
		logic [7:0] idx;
		logic [7:0] data;
	} usr_wr_t;

	typedef enum logic [4:0] {
		USR_ST_OFF   = 5'b00001,
		USR_ST_ASYNC = 5'b00010,
		USR_ST_SIDLE = 5'b00100,
		USR_ST_SRX   = 5'b01000,
		USR_ST_STX   = 5'b10000
	} usr_state_t;

	// Register select decode
	function automatic logic usr_hit(input logic [7:0] idx, input logic [7:0] reg_idx);
		return idx == reg_idx;
	endfunction : usr_hit
endpackage : usr_pkg

// ===== design/usr_rate_gen.sv
// Free-running bit rate generator with mode prescaler
`timescale 1ns/1ps
`default_nettype none
module usr_rate_gen (
	input  wire logic       hclk,      // System clock
	input  wire logic       hresetn,   // Async reset, active low
	input  wire logic       sync_mode, // Selects the short prescale
	input  wire logic       restart,   // Divisor was written
	input  wire logic [7:0] divisor,   // Period minus one
	output logic            tick,      // One pulse per bit period
	output logic            ck_high    // First half of bit period
);
	import usr_pkg::*;

	logic [5:0] pre;
	logic [7:0] cnt;
	logic [5:0] pre_top;
	logic       pre_wrap;
	logic [9:0] elapsed;
	logic [9:0] half;

	// ==========================================================
	// Prescale and divisor terminal counts
	assign pre_top  = sync_mode ? USR_PRE_SYNC : USR_PRE_ASYNC;
	assign pre_wrap = (pre == pre_top);
	assign tick     = pre_wrap && (cnt == divisor);
	// Half period compare, exact for the synchronous clock
	assign elapsed  = {cnt, pre[1:0]};
	assign half     = {1'b0, divisor, 1'b0} + 10'h002;
	assign ck_high  = elapsed < half;

	// Counters; a divisor write restarts the period at once
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre <= 6'h00;
			cnt <= 8'h00;
		end else if (restart) begin
			pre <= 6'h00;
			cnt <= 8'h00;
		end else if (pre_wrap) begin
			pre <= 6'h00;
			cnt <= tick ? 8'h00 : cnt + 8'h01;
		end else begin
			pre <= pre + 6'h01;
		end
	end
endmodule : usr_rate_gen
`default_nettype wire

// ===== design/usr_ahb_port.sv
// AHB-Lite slave front end with zero wait states
`timescale 1ns/1ps
`default_nettype none
module usr_ahb_port (
	input  wire logic        hclk,      // System clock
	input  wire logic        hresetn,   // Async reset, active low
	input  wire logic        hsel,      // Slave select
	input  wire logic [31:0] haddr,     // Byte address
	input  wire logic [1:0]  htrans,    // Transfer type
	input  wire logic        hwrite,    // Write when high
	input  wire logic        hready,    // Bus ready
	input  wire logic [31:0] hwdata,    // Write data
	input  wire logic [7:0]  rd_word,   // Read value at rd_idx
	output logic      [7:0]  rd_idx,    // Index of address phase
	output usr_pkg::usr_wr_t wr,        // Data phase write strobe
	output logic      [31:0] hrdata,    // Read data
	output logic             hreadyout, // Always ready
	output logic             hresp      // Always OKAY
);
	import usr_pkg::*;

	logic       take;
	logic       wr_pend;
	logic [7:0] wr_idx;

	// ==========================================================
	// Address phase decode; out of range reads as index zero
	assign take   = hsel && hready && htrans[1];
	assign rd_idx = (haddr[31:10] == 22'h0) ? haddr[9:2] : 8'h00;
	assign wr     = '{en: wr_pend, idx: wr_idx, data: hwdata[7:0]};

	// Read data is captured at the address phase edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend   <= 1'b0;
			wr_idx    <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_pend <= take && hwrite;
			if (take) begin
				wr_idx <= rd_idx;
			end
			if (take && !hwrite) begin
				hrdata <= {24'h00_0000, rd_word};
			end
		end
	end
endmodule : usr_ahb_port
`default_nettype wire

// ===== design/usr_ctrl.sv
// Serial port control, receive status and rate generation top level
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module usr_ctrl (
	input  wire logic        hclk,                   // System clock
	input  wire logic        hresetn,                // Async reset
	input  wire logic        hsel,                   // Slave select
	input  wire logic [31:0] haddr,                  // Byte address
	input  wire logic [1:0]  htrans,                 // Transfer type
	input  wire logic        hwrite,                 // Write cycle
	input  wire logic [2:0]  hsize,                  // Word only
	input  wire logic [31:0] hwdata,                 // Write data
	input  wire logic        hready,                 // Bus ready
	output logic      [31:0] hrdata,                 // Read data
	output logic             hreadyout,              // Slave ready
	output logic             hresp,                  // Response
	input  wire logic        rx_byte_done,           // Byte received
	input  wire logic        rx_overrun_event,       // Receive overrun
	input  wire logic        rcv_data_read,          // Data reg read
	input  wire logic        rcv_frame_error,        // Error of head
	input  wire logic        rcv_ninth_bit,          // Ninth of head
	input  wire logic        tsr_empty_in,           // Shifter empty
	input  wire logic        tx_serial_data,         // Shifter output
	input  wire logic        receive_data_pin_level, // Data pin
	output logic             receive_data_pin_drive, // Data drive
	output logic             receive_data_pin_oe_n,  // Data enable
	input  wire logic        transmit_clock_pin_level, // Clock pin
	output logic             transmit_clock_pin_drive, // Clock drive
	output logic             transmit_clock_pin_oe_n,  // Clock enable
	output logic             rx_run,                 // Receiver on
	output logic             tx_run,                 // Transmitter on
	output logic             sync_active,            // Sync mode
	output logic             rx_nine,                // Nine bit rx
	output logic             tx_nine,                // Nine bit tx
	output logic             tx_ninth,               // Ninth tx bit
	output logic             bit_tick,               // Rate pulse
	output logic             rx_line,                // Data pin seen
	output logic             clk_line                // Clock pin seen
);
	import usr_pkg::*;

	// ==========================================================
	// Declarations
	usr_wr_t    wr;
	usr_state_t state;
	usr_state_t next_state;
	logic [7:0] rd_idx;
	logic [7:0] rd_word;
	logic       wr_rcv;
	logic       wr_xmt;
	logic       wr_div;
	logic       port_enable;
	logic       rx_nine_bit_select;
	logic       single_receive_enable;
	logic       continuous_receive_enable;
	logic       framing_error_flag;
	logic       overrun_flag;
	logic       rx_ninth_data_bit;
	logic       clock_source_select;
	logic       tx_nine_bit_select;
	logic       transmit_enable;
	logic       sync_mode;
	logic       shift_register_empty;
	logic       tx_ninth_data_bit;
	logic [7:0] baud_divisor;
	logic [7:0] rcv_word;
	logic [7:0] xmt_word;
	logic       sync_master;
	logic       single_done;
	logic       cont_cleared;
	logic       gen_tick;
	logic       gen_ck_high;
	logic       next_rx_run;
	logic       next_tx_run;
	logic       next_dt_drive;
	logic       next_dt_oe_n;
	logic       next_ck_drive;
	logic       next_ck_oe_n;
	logic       next_single;
	logic       next_overrun;

	// ==========================================================
	// Bus front end
	usr_ahb_port u_port (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hready    (hready),
		.hwdata    (hwdata),
		.rd_word   (rd_word),
		.rd_idx    (rd_idx),
		.wr        (wr),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp)
	);

	// ==========================================================
	// Rate generator, shared by both modes
	usr_rate_gen u_rate (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.sync_mode (sync_mode),
		.restart   (wr_div),
		.divisor   (baud_divisor),
		.tick      (gen_tick),
		.ck_high   (gen_ck_high)
	);

	// ==========================================================
	// Register decode; unmapped indices read zero, writes dropped
	assign wr_rcv = wr.en && usr_hit(wr.idx, USR_IDX_RCV);
	assign wr_xmt = wr.en && usr_hit(wr.idx, USR_IDX_XMT);
	assign wr_div = wr.en && usr_hit(wr.idx, USR_IDX_DIV);

	// Read views; bit 3 and transmit bits 3..2 are hard zero
	assign rcv_word = {port_enable, rx_nine_bit_select,
		single_receive_enable, continuous_receive_enable,
		1'b0, framing_error_flag, overrun_flag,
		rx_ninth_data_bit};
	assign xmt_word = {clock_source_select, tx_nine_bit_select,
		transmit_enable, sync_mode, 2'b00,
		shift_register_empty, tx_ninth_data_bit};
	assign rd_word = usr_hit(rd_idx, USR_IDX_RCV) ? rcv_word :
		usr_hit(rd_idx, USR_IDX_XMT) ? xmt_word :
		usr_hit(rd_idx, USR_IDX_DIV) ? baud_divisor : 8'h00;

	// ==========================================================
	// Receive control side effects
	assign sync_master = sync_mode && clock_source_select;
	// Single byte done only counts for a sync master
	assign single_done = rx_byte_done && port_enable
		&& sync_master && !continuous_receive_enable;
	assign cont_cleared = wr_rcv && !wr.data[USR_RC_CRE]
		&& continuous_receive_enable;
	// Software set wins over the hardware clear
	assign next_single = wr_rcv ? wr.data[USR_RC_SRE]
		: (single_done ? 1'b0 : single_receive_enable);
	// Overrun event wins over the clearing write
	assign next_overrun = rx_overrun_event ? 1'b1
		: (cont_cleared ? 1'b0 : overrun_flag);

	// Receive status/control register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_enable               <= USR_RCV_RST[USR_RC_PEN];
			rx_nine_bit_select        <= USR_RCV_RST[USR_RC_RX9];
			single_receive_enable     <= USR_RCV_RST[USR_RC_SRE];
			continuous_receive_enable <= USR_RCV_RST[USR_RC_CRE];
			framing_error_flag        <= USR_RCV_RST[USR_RC_FER];
			overrun_flag              <= USR_RCV_RST[USR_RC_OVR];
			rx_ninth_data_bit         <= USR_RCV_RST[USR_RC_R9D];
		end else begin
			if (wr_rcv) begin
				port_enable               <= wr.data[USR_RC_PEN];
				rx_nine_bit_select        <= wr.data[USR_RC_RX9];
				continuous_receive_enable <= wr.data[USR_RC_CRE];
			end
			single_receive_enable <= next_single;
			overrun_flag          <= next_overrun;
			// Status of the word at the head refreshes on its read
			if (rcv_data_read) begin
				framing_error_flag <= rcv_frame_error;
				rx_ninth_data_bit  <= rcv_ninth_bit;
			end
		end
	end

	// ==========================================================
	// Transmit status/control and divisor registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clock_source_select  <= USR_XMT_RST[USR_TC_CSS];
			tx_nine_bit_select   <= USR_XMT_RST[USR_TC_TX9];
			transmit_enable      <= USR_XMT_RST[USR_TC_TEN];
			sync_mode            <= USR_XMT_RST[USR_TC_SYN];
			shift_register_empty <= USR_XMT_RST[USR_TC_EMP];
			tx_ninth_data_bit    <= USR_XMT_RST[USR_TC_T9D];
			baud_divisor         <= USR_DIV_RST;
		end else begin
			if (wr_xmt) begin
				clock_source_select <= wr.data[USR_TC_CSS];
				tx_nine_bit_select  <= wr.data[USR_TC_TX9];
				transmit_enable     <= wr.data[USR_TC_TEN];
				sync_mode           <= wr.data[USR_TC_SYN];
				tx_ninth_data_bit   <= wr.data[USR_TC_T9D];
			end
			// Any byte value is legal, no range clipping
			if (wr_div) begin
				baud_divisor <= wr.data;
			end
			shift_register_empty <= tsr_empty_in;
		end
	end

	// ==========================================================
	// Sequencing state; receive beats transmit in sync mode
	always_comb begin
		case (1'b1)
			!port_enable: begin
				next_state = USR_ST_OFF;
			end
			!sync_mode: begin
				next_state = USR_ST_ASYNC;
			end
			continuous_receive_enable: begin
				next_state = USR_ST_SRX;
			end
			single_receive_enable && clock_source_select: begin
				next_state = USR_ST_SRX;
			end
			transmit_enable: begin
				next_state = USR_ST_STX;
			end
			default: begin
				next_state = USR_ST_SIDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= USR_ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// Pin direction and drive, from the next state
	// Registering keeps every pin glitch free without lagging the state register
	always_comb begin
		next_rx_run   = 1'b0;
		next_tx_run   = 1'b0;
		next_dt_drive = 1'b1;
		next_dt_oe_n  = 1'b1;
		next_ck_drive = 1'b1;
		next_ck_oe_n  = 1'b1;
		case (next_state)
			USR_ST_OFF: begin
				next_dt_oe_n = 1'b1;
			end
			USR_ST_ASYNC: begin
				next_rx_run   = continuous_receive_enable;
				next_tx_run   = transmit_enable;
				next_ck_oe_n  = 1'b0;
				next_ck_drive = transmit_enable ? tx_serial_data : 1'b1;
			end
			USR_ST_SRX: begin
				next_rx_run   = 1'b1;
				next_ck_oe_n  = !clock_source_select;
				next_ck_drive = gen_ck_high;
			end
			USR_ST_STX: begin
				next_tx_run   = 1'b1;
				next_dt_oe_n  = 1'b0;
				next_dt_drive = tx_serial_data;
				next_ck_oe_n  = !clock_source_select;
				next_ck_drive = gen_ck_high;
			end
			USR_ST_SIDLE: begin
				next_ck_oe_n  = !clock_source_select;
				next_ck_drive = 1'b1;
			end
			default: begin
				next_dt_oe_n = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_run                   <= 1'b0;
			tx_run                   <= 1'b0;
			receive_data_pin_drive   <= 1'b1;
			receive_data_pin_oe_n    <= 1'b1;
			transmit_clock_pin_drive <= 1'b1;
			transmit_clock_pin_oe_n  <= 1'b1;
		end else begin
			rx_run                   <= next_rx_run;
			tx_run                   <= next_tx_run;
			receive_data_pin_drive   <= next_dt_drive;
			receive_data_pin_oe_n    <= next_dt_oe_n;
			transmit_clock_pin_drive <= next_ck_drive;
			transmit_clock_pin_oe_n  <= next_ck_oe_n;
		end
	end

	// Mode copies and rate pulse for the shift datapaths
	// A slave runs from the peer clock, so its tick is withheld
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_active <= 1'b0;
			rx_nine     <= 1'b0;
			tx_nine     <= 1'b0;
			tx_ninth    <= 1'b0;
			bit_tick    <= 1'b0;
			rx_line     <= 1'b1;
			clk_line    <= 1'b1;
		end else begin
			sync_active <= sync_mode;
			rx_nine     <= rx_nine_bit_select;
			tx_nine     <= tx_nine_bit_select;
			tx_ninth    <= tx_ninth_data_bit;
			bit_tick    <= gen_tick && port_enable
				&& (!sync_mode || clock_source_select);
			rx_line     <= receive_data_pin_level;
			clk_line    <= transmit_clock_pin_level;
		end
	end

	// hsize is not decoded: only whole word transfers are used
endmodule : usr_ctrl
`default_nettype wire

// ===== tb/usr_ctrl_asserts.sv
// Concurrent checks on the ports of the serial port control block
`timescale 1ns/1ps
`default_nettype none
module usr_ctrl_asserts (
	input  wire logic        hclk,                    // System clock
	input  wire logic        hresetn,                 // Async reset
	input  wire logic        hsel,                    // Slave select
	input  wire logic [31:0] haddr,                   // Byte address
	input  wire logic [1:0]  htrans,                  // Transfer type
	input  wire logic        hwrite,                  // Write cycle
	input  wire logic        hready,                  // Bus ready
	input  wire logic [31:0] hwdata,                  // Write data
	input  wire logic [31:0] hrdata,                  // Read data
	input  wire logic        bit_tick,                // Rate pulse
	input  wire logic        rx_run,                  // Receiver on
	input  wire logic        tx_run,                  // Transmitter on
	input  wire logic        receive_data_pin_oe_n,   // Data enable
	input  wire logic        transmit_clock_pin_oe_n  // Clock enable
);
	// ==========================================================
	// Shadow of written control values and tick spacing
	logic        wa_v;
	logic [31:0] wa;
	logic        rd_r;
	logic [7:0]  r_sh;
	logic [7:0]  x_sh;
	logic [7:0]  d_sh;
	logic [15:0] gap;
	logic        have;
	logic [1:0]  q;
	wire         take = hsel && hready && htrans[1];

	// One process keeps the shadow, so writes and gaps stay aligned
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{wa_v, wa, rd_r, r_sh, x_sh, d_sh, have, q} <= '0;
			gap <= 16'h0;
		end else begin
			wa_v <= take && hwrite;
			wa   <= haddr;
			rd_r <= take && !hwrite && haddr == 32'h4c;
			if (wa_v && wa == 32'h4c) r_sh <= hwdata[7:0];
			if (wa_v && wa == 32'h54) x_sh <= hwdata[7:0];
			if (wa_v && wa == 32'h5c) d_sh <= hwdata[7:0];
			q    <= wa_v ? 2'd0 : (q == 2'd3 ? q : q + 2'd1);
			gap  <= bit_tick ? 16'd1 : gap + 16'd1;
			have <= wa_v ? 1'b0 : (bit_tick ? 1'b1 : have);
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ==========================================================
	// Assertions
	chk_rcv_gap: assert property (
		rd_r |-> !hrdata[3]) else $error("receive reg bit 3 not zero");
	chk_tick_gap: assert property (
		bit_tick && have |=> !bit_tick [*3]) else $error("rate ticks too close");
	chk_rate_fixed: assert property (
		bit_tick && have |-> gap == (x_sh[4] ? 16'd4 : 16'd64) * ({8'h0, d_sh} + 16'd1))
		else $error("bit period wrong");
	chk_port_off: assert property (
		q == 2'd3 && !r_sh[7] |-> receive_data_pin_oe_n && transmit_clock_pin_oe_n
		&& !rx_run && !tx_run && !bit_tick) else $error("disabled port still active");
	chk_rx_wins: assert property (
		q == 2'd3 && x_sh[4] && rx_run |-> receive_data_pin_oe_n)
		else $error("sync receive drives data pin");
	chk_tx_drives: assert property (
		q == 2'd3 && x_sh[4] && r_sh[7] && tx_run && !rx_run |-> !receive_data_pin_oe_n)
		else $error("sync transmit leaves data pin");
	chk_slave_clk: assert property (
		q == 2'd3 && r_sh[7] && x_sh[4] && !x_sh[7] |-> transmit_clock_pin_oe_n && !bit_tick)
		else $error("slave drives clock");
	chk_master_clk: assert property (
		q == 2'd3 && r_sh[7] && x_sh[4] && x_sh[7] |-> !transmit_clock_pin_oe_n)
		else $error("master leaves clock pin");
endmodule : usr_ctrl_asserts
`default_nettype wire

// ===== tb/usr_peer.sv
// Serial peer model: line pull-ups, slave clock source and data pattern
`timescale 1ns/1ps
`default_nettype none
module usr_peer (
	input  wire logic hclk,   // System clock
	input  wire logic frame,  // Peer is sending a frame
	input  wire logic d_oe_n, // Device data enable
	input  wire logic d_drv,  // Device data value
	input  wire logic c_oe_n, // Device clock enable
	input  wire logic c_drv,  // Device clock value
	output logic      d_lvl,  // Data wire
	output logic      c_lvl   // Clock wire
);
	// ==========================================================
	// Peer clock stands high outside frames; pattern moves each bit
	logic [2:0] ph  = 3'h0;
	logic       pk  = 1'b1;
	logic [7:0] pat = 8'h35;
	always @(posedge hclk) begin
		ph <= frame ? ph + 3'h1 : 3'h0;
		pk <= frame ? ~ph[2] : 1'b1;
		if (frame && ph == 3'h7)
			pat <= {pat[6:0], pat[7]};
	end
	// Driving party wins; pull-up holds the line when nobody drives
	assign d_lvl = !d_oe_n ? d_drv : (frame ? pat[7] : 1'b1);
	assign c_lvl = !c_oe_n ? c_drv : pk;
endmodule : usr_peer
`default_nettype wire

// ===== tb/usr_ctrl_tb.sv
// Self-checking bench for the serial port control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
	$display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module usr_ctrl_tb;
	import usr_pkg::*;
	typedef struct packed {
		logic        w;
		logic [31:0] a;
		logic [7:0]  d;
		logic [7:0]  e;
	} usr_row_t;
	localparam logic [31:0] A_RCV = {22'h0, USR_IDX_RCV, 2'b00};
	localparam logic [31:0] A_XMT = {22'h0, USR_IDX_XMT, 2'b00};
	localparam logic [31:0] A_DIV = {22'h0, USR_IDX_DIV, 2'b00};
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0]  htrans = 2'b00;
	logic [2:0]  ev = 3'h0;
	logic        fe = 1'b0, n9 = 1'b0, tsr_e = 1'b1, txd = 1'b1, frame = 1'b0;
	logic        hreadyout, hresp, d_lvl, d_drv, d_oe_n, c_lvl, c_drv, c_oe_n;
	logic        rx_run, tx_run, rx_nine, bit_tick, clk_line, v;
	logic        sync_active, tx_nine, tx_ninth, rx_line;
	int          error_cnt = 0, comparisons = 0, n;
	// Reset reads, then writes with the value read back
	usr_row_t rows [0:7] = '{'{1'b0, A_RCV, 8'h00, 8'h00}, '{1'b0, A_XMT, 8'h00, 8'h02},
		'{1'b0, A_DIV, 8'h00, 8'h00}, '{1'b1, A_RCV, 8'hff, 8'hf0},
		'{1'b1, A_XMT, 8'hfd, 8'hf3}, '{1'b1, A_DIV, 8'ha5, 8'ha5},
		'{1'b1, 32'h60, 8'h55, 8'h00}, '{1'b1, A_RCV, 8'h00, 8'h00}};
	// Transmit ctrl, receive ctrl, receive ctrl after one byte
	logic [23:0] srx [0:3] = '{24'h90a080, 24'h10a0a0, 24'h90b0b0, 24'h00a0a0};

	always #4 hclk = ~hclk;

	usr_ctrl dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_byte_done(ev[0]),
		.rx_overrun_event(ev[1]), .rcv_data_read(ev[2]), .rcv_frame_error(fe),
		.rcv_ninth_bit(n9), .tsr_empty_in(tsr_e), .tx_serial_data(txd),
		.receive_data_pin_level(d_lvl), .receive_data_pin_drive(d_drv),
		.receive_data_pin_oe_n(d_oe_n), .transmit_clock_pin_level(c_lvl),
		.transmit_clock_pin_drive(c_drv), .transmit_clock_pin_oe_n(c_oe_n), .rx_run,
		.tx_run, .sync_active, .rx_nine, .tx_nine, .tx_ninth, .bit_tick,
		.rx_line, .clk_line);
	usr_peer peer_u (.hclk, .frame, .d_oe_n, .d_drv, .c_oe_n, .c_drv, .d_lvl, .c_lvl);

	// ==========================================================
	// Bus master: address phase, then data phase, each held to hready
	task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d,
			output logic [31:0] q);
		@(posedge hclk);
		{hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, a, w};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'b00, 24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic chk_rd(input logic [31:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		`CHK(q, {24'h0, e})
	endtask : chk_rd
	task automatic pulse(input int i);
		@(posedge hclk);
		ev[i] <= 1'b1;
		@(posedge hclk);
		ev[i] <= 1'b0;
	endtask : pulse
	task automatic tick_gap(output int c);
		c = 0;
		do @(posedge hclk); while (bit_tick !== 1'b1);
		do begin @(posedge hclk); c++; end while (bit_tick !== 1'b1);
	endtask : tick_gap
	task automatic give_verdict();
		if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	// ==========================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			chk_rd(rows[i].a, rows[i].e);
		end
		// Response stays OKAY; mode copies follow the transmit register
		`CHK({hresp, sync_active, tx_nine, tx_ninth}, 4'b0111)
		// Overrun survives other writes, goes with continuous receive
		wr(A_RCV, 8'h90);
		pulse(1);
		chk_rd(A_RCV, 8'h92);
		wr(A_RCV, 8'hd0);
		chk_rd(A_RCV, 8'hd2);
		`CHK(rx_nine, 1'b1)
		wr(A_RCV, 8'h80);
		chk_rd(A_RCV, 8'h80);
		// Status of the word taken on each data read
		{fe, n9} <= 2'b11;
		pulse(2);
		chk_rd(A_RCV, 8'h85);
		{fe, n9} <= 2'b00;
		pulse(2);
		chk_rd(A_RCV, 8'h80);
		// Single receive across the modes
		foreach (srx[i]) begin
			wr(A_XMT, srx[i][23:16]);
			wr(A_RCV, srx[i][15:8]);
			pulse(0);
			chk_rd(A_RCV, srx[i][7:0]);
		end
		// Sync master: receive holds the data pin, then transmit drives it
		{tsr_e, txd} <= 2'b00;
		wr(A_XMT, 8'hb0);
		wr(A_RCV, 8'ha0);
		chk_rd(A_XMT, 8'hb0);
		`CHK({d_oe_n, rx_run, c_oe_n}, 3'b110)
		wr(A_RCV, 8'h80);
		repeat (3) @(posedge hclk);
		`CHK({d_oe_n, tx_run, d_drv}, 3'b010)
		// Sync slave follows the peer clock
		wr(A_XMT, 8'h30);
		frame <= 1'b1;
		repeat (8) @(posedge hclk);
		v = clk_line;
		repeat (4) @(posedge hclk);
		`CHK({c_oe_n, clk_line, rx_line}, {1'b1, ~v, 1'b0})
		frame <= 1'b0;
		wr(A_RCV, 8'h00);
		repeat (3) @(posedge hclk);
		`CHK({d_oe_n, c_oe_n, rx_run, tx_run}, 4'b1100)
		// Bit period at both prescales and the divisor bounds
		wr(A_XMT, 8'h00);
		wr(A_RCV, 8'h80);
		wr(A_DIV, 8'h00);
		tick_gap(n);
		`CHK(n, 64)
		wr(A_DIV, 8'hff);
		tick_gap(n);
		`CHK(n, 16384)
		wr(A_XMT, 8'h90);
		wr(A_DIV, 8'h02);
		tick_gap(n);
		`CHK(n, 12)
		// A divisor write mid-period must not wait out the old one
		wr(A_XMT, 8'h00);
		wr(A_DIV, 8'hff);
		repeat (200) @(posedge hclk);
		wr(A_DIV, 8'h00);
		n = 0;
		do begin @(posedge hclk); n++; end while (bit_tick !== 1'b1 && n < 300);
		`CHK(n <= 100, 1'b1)
		// Mid-run reset puts registers, read data and pins back to idle
		wr(A_RCV, 8'h90);
		wr(A_DIV, 8'h5a);
		`CHK(rx_run, 1'b1)
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		`CHK({hrdata, d_oe_n, c_oe_n, rx_run, bit_tick, rx_line}, {32'h0, 5'b11001})
		hresetn <= 1'b1;
		chk_rd(A_RCV, USR_RCV_RST);
		chk_rd(A_DIV, USR_DIV_RST);
		give_verdict();
	end

	// Hang guard well beyond the longest expected run
	initial begin
		repeat (60000) @(posedge hclk);
		error_cnt++;
		give_verdict();
	end
endmodule : usr_ctrl_tb

bind usr_ctrl usr_ctrl_asserts chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hwdata, .hrdata, .bit_tick, .rx_run, .tx_run, .receive_data_pin_oe_n,
	.transmit_clock_pin_oe_n);
`default_nettype wire
